// *** bench/rhda_asserts.sv ***
// assertion checker for the root hub descriptor register bank
`timescale 1ns/100ps
`default_nettype none

module rhda_asserts #(
  parameter int NUM_PORTS = 2
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [NUM_PORTS-1:0] overcurrent_pin_in,
  input wire logic [NUM_PORTS-1:0] port_power_out,
  input wire logic [NUM_PORTS-1:0] overcurrent_out,
  input wire logic power_good_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  // -----------------------------------------------------------------
  // bus phases
  // -----------------------------------------------------------------
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_answer;
    psel_in && penable_in && pready_out;
  endsequence

  a_ready_next: assert property (s_setup |=> s_answer) else $error("setup not answered next cycle");
  a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready_out && paddr_in[11:2] != 10'h012 && paddr_in[11:2] != 10'h013
    |-> pslverr_out) else $error("unmapped access not refused");
  a_err_mapped: assert property (pready_out && paddr_in[11:2] == 10'h012 |-> !pslverr_out)
    else $error("descriptor access refused");
  a_data_idle: assert property (!pready_out |-> prdata_out == 32'h0) else $error("read data outside answer");
  a_fixed_fields: assert property (s_answer and (!pwrite_in && paddr_in[11:2] == 10'h012)
    |-> prdata_out[10] == 1'b0 && prdata_out[7:0] == 8'(NUM_PORTS)) else $error("fixed field wrong");
  a_pgood_off: assert property (port_power_out == '0 |=> !power_good_out) else $error("good with no power");
  a_pgood_wait: assert property ($rose(power_good_out) |-> $past(|port_power_out, 2))
    else $error("good too soon");
  a_oc_sync: assert property ($rose(|overcurrent_out) |-> $past(|overcurrent_pin_in, 3))
    else $error("overcurrent without pin");
endmodule // rhda_asserts

bind rhda_root_hub_desc rhda_asserts #(.NUM_PORTS(NUM_PORTS)) rhda_asserts_i (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .paddr_in(paddr_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .overcurrent_pin_in(overcurrent_pin_in), .port_power_out(port_power_out),
  .overcurrent_out(overcurrent_out), .power_good_out(power_good_out));

`default_nettype wire

// *** bench/testbench.sv ***
// self-checking testbench for the root hub descriptor register bank
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [11:0] paddr_in = 12'h000;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] strb = 4'hF;
  // global set, global clear, port set [1:0], port clear [1:0]
  logic [5:0] cmd = 6'h00;
  logic [1:0] oc_pin = 2'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic power_good_out;
  logic [1:0] port_power_out;
  logic [1:0] overcurrent_out;
  int err_count = 0;
  int n_tests = 0;
  logic [64:0] exp_q[$];
  logic [64:0] note;
  logic [31:0] v;
  int k;

  always #25 clk_sys_in = ~clk_sys_in;

  // short power-good unit keeps the wait visible in a few cycles
  rhda_root_hub_desc #(.NUM_PORTS(2), .UNIT_CYCLES(4)) rhda_root_hub_desc_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .paddr_in(paddr_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .pstrb_in(strb),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .global_power_set_in(cmd[5]), .global_power_clr_in(cmd[4]), .port_power_set_in(cmd[3:2]),
    .port_power_clr_in(cmd[1:0]), .overcurrent_pin_in(oc_pin), .port_power_out(port_power_out),
    .overcurrent_out(overcurrent_out), .power_good_out(power_good_out));

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // d is write data, or expected read data under mask m
  task automatic apb(input int w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
    input int e);
    int n;
    n = 0;
    exp_q.push_back({e[0], m, d & m});
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w[0];
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_sys_in);
    end
    // a slave that never answers ends the run as a mismatch
    if (n >= 50)
    begin
      err_count++;
      stop_test();
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic pulse(input logic [5:0] c, input logic [1:0] exp);
    @(posedge clk_sys_in);
    cmd <= c;
    @(posedge clk_sys_in);
    cmd <= 6'h00;
    #1;
    check({30'h0, port_power_out}, {30'h0, exp});
  endtask

  always @(posedge clk_sys_in)
  begin
    if (pready_out === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      check(prdata_out & note[63:32], note[31:0]);
      check({31'h0, pslverr_out}, {31'h0, note[64]});
    end
  end

  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h8E92FE78));
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    apb(0, 12'h048, 32'hFF000902, '1, 0);
    apb(0, 12'h04C, 32'h00060000, '1, 0);
    $display("test reset values done");
    for (k = 0; k < 4; k++)
    begin
      v = $urandom();
      v[23:13] = 11'h000;
      v[10] = 1'b1;
      apb(1, 12'h048, v, 32'h0, 0);
      apb(0, 12'h048, {v[31:11], 1'b0, v[9:8], 8'h02}, '1, 0);
    end
    // only the top byte strobed: the rest of the word must stay as it was
    strb <= 4'h8;
    apb(1, 12'h048, 32'h5A000000, 32'h0, 0);
    strb <= 4'hF;
    apb(0, 12'h048, {8'h5A, v[23:11], 1'b0, v[9:8], 8'h02}, '1, 0);
    apb(1, 12'h050, 32'hFFFFFFFF, 32'h0, 1);
    apb(0, 12'h050, 32'h0, '1, 1);
    $display("test register access done");
    apb(1, 12'h048, 32'h01000800, 32'h0, 0);
    pulse(6'h10, 2'b00);
    pulse(6'h20, 2'b11);
    repeat (2) @(posedge clk_sys_in);
    #1 check({31'h0, power_good_out}, 32'h0);
    repeat (10) @(posedge clk_sys_in);
    #1 check({31'h0, power_good_out}, 32'h1);
    pulse(6'h03, 2'b11);
    pulse(6'h10, 2'b00);
    pulse(6'h0C, 2'b00);
    apb(1, 12'h04C, 32'h00020000, 32'h0, 0);
    apb(1, 12'h048, 32'h01000900, 32'h0, 0);
    pulse(6'h20, 2'b10);
    pulse(6'h04, 2'b11);
    pulse(6'h10, 2'b01);
    pulse(6'h01, 2'b00);
    apb(1, 12'h048, 32'h01000A00, 32'h0, 0);
    pulse(6'h00, 2'b11);
    $display("test power switching done");
    @(posedge clk_sys_in);
    oc_pin <= 2'b01;
    repeat (5) @(posedge clk_sys_in);
    #1 check({30'h0, overcurrent_out}, 32'h1);
    apb(1, 12'h048, 32'h01000200, 32'h0, 0);
    repeat (5) @(posedge clk_sys_in);
    #1 check({30'h0, overcurrent_out}, 32'h3);
    apb(1, 12'h048, 32'h01001200, 32'h0, 0);
    repeat (5) @(posedge clk_sys_in);
    #1 check({30'h0, overcurrent_out}, 32'h0);
    @(posedge clk_sys_in);
    oc_pin <= 2'b00;
    $display("test overcurrent done");
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1 check({30'h0, port_power_out}, 32'h0);
    apb(0, 12'h048, 32'hFF000902, '1, 0);
    repeat (3) @(posedge clk_sys_in);
    $display("test second reset done");
    stop_test();
  end

  // a hang counts as a mismatch
  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    err_count++;
    stop_test();
  end
endmodule // testbench

`default_nettype wire

// *** hdl/rhda_pkg.sv ***
// constants, field layouts and carrier types of the root hub descriptor register bank

package rhda_pkg;

  // -----------------------------------------------------------------
  // bus geometry and offsets
  // -----------------------------------------------------------------
  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;
  localparam logic [11:0] DESC_FIRST_OFFSET = 12'h048;
  localparam logic [11:0] POWER_MASK_OFFSET = 12'h04C;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int DELAY_LSB = 24;
  localparam int RSVD_LSB = 13;
  localparam int NO_OC_PROTECT_BIT = 12;
  localparam int OC_REPORT_MODE_BIT = 11;
  localparam int COMPOUND_BIT = 10;
  localparam int NO_SWITCHING_BIT = 9;
  localparam int SWITCH_SCHEME_BIT = 8;
  localparam int PORT_COUNT_LSB = 0;
  localparam int POWER_MASK_LSB = 16;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] DELAY_RESET = 8'hFF;
  localparam logic [10:0] RSVD_RESET = 11'h000;
  localparam logic NO_OC_PROTECT_RESET = 1'b0;
  localparam logic NO_SWITCHING_RESET = 1'b0;
  localparam logic SWITCH_SCHEME_RESET = 1'b1;
  localparam logic OC_REPORT_MODE_RESET = SWITCH_SCHEME_RESET;
  localparam logic COMPOUND_VALUE = 1'b0;
  localparam logic [15:0] POWER_MASK_RESET_2P = 16'h0006;
  localparam logic [15:0] POWER_MASK_RESET_1P = 16'h0002;
  // mask bit 11 is read-only
  localparam logic [15:0] POWER_MASK_WRITABLE = 16'hF7FF;
  localparam logic [7:0] PORT_COUNT_MIN = 8'h01;
  localparam logic [7:0] PORT_COUNT_MAX = 8'h0F;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int POWER_GOOD_UNIT_MS = 2;
  localparam int POWER_GOOD_UNIT_CYCLES = POWER_GOOD_UNIT_MS * (CLK_FREQ_HZ / 1000);

  // -----------------------------------------------------------------
  // carrier types
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] power_good_delay;
    logic [10:0] reserved;
    logic no_overcurrent_protect;
    logic overcurrent_report_mode;
    logic compound_device_flag;
    logic no_power_switching;
    logic power_switching_scheme;
    logic [7:0] downstream_port_count;
  } rhda_desc_s;

  typedef enum logic [1:0] {
    RHDA_PG_IDLE = 2'b00,
    RHDA_PG_WAIT = 2'b01,
    RHDA_PG_GOOD = 2'b11
  } rhda_pg_state_e;

endpackage

// *** hdl/rhda_root_hub_desc.sv ***
// root hub descriptor register bank with APB slave, port power control and overcurrent reporting
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module rhda_root_hub_desc #(
  parameter int NUM_PORTS = 2,
  parameter int unsigned UNIT_CYCLES = rhda_pkg::POWER_GOOD_UNIT_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [rhda_pkg::APB_ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rhda_pkg::APB_DATA_W-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [rhda_pkg::APB_DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic global_power_set_in,
  input wire logic global_power_clr_in,
  input wire logic [NUM_PORTS-1:0] port_power_set_in,
  input wire logic [NUM_PORTS-1:0] port_power_clr_in,
  input wire logic [NUM_PORTS-1:0] overcurrent_pin_in,
  output logic [NUM_PORTS-1:0] port_power_out,
  output logic [NUM_PORTS-1:0] overcurrent_out,
  output logic power_good_out
);

  // -----------------------------------------------------------------
  // configuration constants
  // -----------------------------------------------------------------
  localparam logic [7:0] PORT_COUNT_CFG = 8'(NUM_PORTS);
  localparam logic [15:0] POWER_MASK_RESET =
    (NUM_PORTS >= 2) ? rhda_pkg::POWER_MASK_RESET_2P : rhda_pkg::POWER_MASK_RESET_1P;
  localparam int TICK_W = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(UNIT_CYCLES - 1);

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  function automatic logic hits(input logic [11:0] addr, input logic [11:0] offset);
    hits = (addr[11:2] == offset[11:2]);
  endfunction

  function automatic logic [31:0] strobe_merge(input logic [31:0] old_word, input logic [31:0] new_word,
                                               input logic [3:0] strb);
    logic [31:0] merged;
    merged = old_word;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        merged[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    strobe_merge = merged;
  endfunction

  // -----------------------------------------------------------------
  // apb slave
  // -----------------------------------------------------------------
  rhda_pkg::rhda_desc_s desc_reg;
  logic [15:0] power_mask_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  logic setup_phase;
  logic access_done;
  logic hit_desc;
  logic hit_mask;
  logic [31:0] read_word;
  logic [31:0] desc_merged;
  logic [31:0] mask_word;
  logic [15:0] mask_merged;

  assign setup_phase = psel_in & ~penable_in;
  // one wait-free access cycle: pready rises in the first access cycle
  assign access_done = psel_in & penable_in & pready_reg;
  assign hit_desc = hits(paddr_in, rhda_pkg::DESC_FIRST_OFFSET);
  assign hit_mask = hits(paddr_in, rhda_pkg::POWER_MASK_OFFSET);

  always_comb
  begin
    read_word = 32'h0000_0000;
    if (hit_desc)
    begin
      read_word = desc_reg;
    end
    else if (hit_mask)
    begin
      read_word[rhda_pkg::POWER_MASK_LSB +: 16] = power_mask_reg;
    end
  end

  assign desc_merged = strobe_merge(desc_reg, pwdata_in, pstrb_in);
  assign mask_word = strobe_merge({power_mask_reg, 16'h0000}, pwdata_in, pstrb_in);
  assign mask_merged = mask_word[31:16];

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= setup_phase;
      // unmapped offsets answer with an error and zero data
      pslverr_reg <= setup_phase & ~hit_desc & ~hit_mask;
      prdata_reg <= (setup_phase & ~pwrite_in) ? read_word : 32'h0000_0000;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;

  // -----------------------------------------------------------------
  // descriptor register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      desc_reg.power_good_delay <= rhda_pkg::DELAY_RESET;
      desc_reg.reserved <= rhda_pkg::RSVD_RESET;
      desc_reg.no_overcurrent_protect <= rhda_pkg::NO_OC_PROTECT_RESET;
      desc_reg.overcurrent_report_mode <= rhda_pkg::OC_REPORT_MODE_RESET;
      desc_reg.compound_device_flag <= rhda_pkg::COMPOUND_VALUE;
      desc_reg.no_power_switching <= rhda_pkg::NO_SWITCHING_RESET;
      desc_reg.power_switching_scheme <= rhda_pkg::SWITCH_SCHEME_RESET;
      desc_reg.downstream_port_count <= PORT_COUNT_CFG;
    end
    else if (access_done & pwrite_in & hit_desc)
    begin
      desc_reg.power_good_delay <= desc_merged[rhda_pkg::DELAY_LSB +: 8];
      // stored as written; software keeps these at zero
      desc_reg.reserved <= desc_merged[rhda_pkg::RSVD_LSB +: 11];
      desc_reg.no_overcurrent_protect <= desc_merged[rhda_pkg::NO_OC_PROTECT_BIT];
      desc_reg.overcurrent_report_mode <= desc_merged[rhda_pkg::OC_REPORT_MODE_BIT];
      desc_reg.compound_device_flag <= rhda_pkg::COMPOUND_VALUE;
      desc_reg.no_power_switching <= desc_merged[rhda_pkg::NO_SWITCHING_BIT];
      desc_reg.power_switching_scheme <= desc_merged[rhda_pkg::SWITCH_SCHEME_BIT];
      desc_reg.downstream_port_count <= PORT_COUNT_CFG;
    end
  end

  // -----------------------------------------------------------------
  // companion power mask
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      power_mask_reg <= POWER_MASK_RESET;
    end
    else if (access_done & pwrite_in & hit_mask)
    begin
      power_mask_reg <= (mask_merged & rhda_pkg::POWER_MASK_WRITABLE) |
                        (power_mask_reg & ~rhda_pkg::POWER_MASK_WRITABLE);
    end
  end

  // -----------------------------------------------------------------
  // port power switching
  // -----------------------------------------------------------------
  logic [NUM_PORTS-1:0] port_power_reg;

  // mask bit 0 is reserved, so port i uses mask bit i+1
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_port_power
      logic port_masked;
      logic take_set;
      logic take_clr;

      assign port_masked = power_mask_reg[gp + 1];

      always_comb
      begin
        take_set = 1'b0;
        take_clr = 1'b0;
        if (!desc_reg.power_switching_scheme)
        begin
          take_set = global_power_set_in;
          take_clr = global_power_clr_in;
        end
        else if (port_masked)
        begin
          take_set = port_power_set_in[gp];
          take_clr = port_power_clr_in[gp];
        end
        else
        begin
          take_set = global_power_set_in;
          take_clr = global_power_clr_in;
        end
      end

      always_ff @(posedge clk_sys_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          port_power_reg[gp] <= 1'b0;
        end
        else if (desc_reg.no_power_switching)
        begin
          port_power_reg[gp] <= 1'b1;
        end
        else if (take_set)
        begin
          // a set and a clear together leave the port powered
          port_power_reg[gp] <= 1'b1;
        end
        else if (take_clr)
        begin
          port_power_reg[gp] <= 1'b0;
        end
      end
    end
  endgenerate

  assign port_power_out = port_power_reg;

  // -----------------------------------------------------------------
  // power-on to power-good timer
  // -----------------------------------------------------------------
  rhda_pkg::rhda_pg_state_e pg_state_reg;
  logic [NUM_PORTS-1:0] power_seen_reg;
  logic [TICK_W-1:0] tick_reg;
  logic [7:0] units_left_reg;
  logic power_good_reg;
  logic power_on_event;

  // any newly powered port restarts the whole wait
  assign power_on_event = |(port_power_reg & ~power_seen_reg);

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      power_seen_reg <= '0;
    end
    else
    begin
      power_seen_reg <= port_power_reg;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pg_state_reg <= rhda_pkg::RHDA_PG_IDLE;
      tick_reg <= '0;
      units_left_reg <= 8'h00;
    end
    else if (~|port_power_reg)
    begin
      pg_state_reg <= rhda_pkg::RHDA_PG_IDLE;
      tick_reg <= '0;
      units_left_reg <= 8'h00;
    end
    else if (power_on_event)
    begin
      pg_state_reg <= rhda_pkg::RHDA_PG_WAIT;
      tick_reg <= '0;
      units_left_reg <= desc_reg.power_good_delay;
    end
    else
    begin
      case (pg_state_reg)
        rhda_pkg::RHDA_PG_WAIT:
        begin
          if (units_left_reg == 8'h00)
          begin
            pg_state_reg <= rhda_pkg::RHDA_PG_GOOD;
          end
          else if (tick_reg == TICK_LAST)
          begin
            tick_reg <= '0;
            units_left_reg <= units_left_reg - 8'h01;
          end
          else
          begin
            tick_reg <= tick_reg + 1'b1;
          end
        end
        rhda_pkg::RHDA_PG_GOOD:
        begin
          pg_state_reg <= rhda_pkg::RHDA_PG_GOOD;
        end
        rhda_pkg::RHDA_PG_IDLE:
        begin
          pg_state_reg <= rhda_pkg::RHDA_PG_IDLE;
        end
        default:
        begin
          pg_state_reg <= rhda_pkg::RHDA_PG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      power_good_reg <= 1'b0;
    end
    else
    begin
      power_good_reg <= (pg_state_reg == rhda_pkg::RHDA_PG_GOOD) & (|port_power_reg) & ~power_on_event;
    end
  end

  assign power_good_out = power_good_reg;

  // -----------------------------------------------------------------
  // overcurrent reporting
  // -----------------------------------------------------------------
  logic [NUM_PORTS-1:0] oc_meta_reg;
  logic [NUM_PORTS-1:0] oc_sync_reg;
  logic [NUM_PORTS-1:0] overcurrent_reg;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      oc_meta_reg <= '0;
      oc_sync_reg <= '0;
    end
    else
    begin
      oc_meta_reg <= overcurrent_pin_in;
      oc_sync_reg <= oc_meta_reg;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      overcurrent_reg <= '0;
    end
    else if (desc_reg.no_overcurrent_protect)
    begin
      overcurrent_reg <= '0;
    end
    else if (desc_reg.overcurrent_report_mode)
    begin
      overcurrent_reg <= oc_sync_reg;
    end
    else
    begin
      // collective mode: one fault shows on every port
      overcurrent_reg <= {NUM_PORTS{|oc_sync_reg}};
    end
  end

  assign overcurrent_out = overcurrent_reg;

endmodule // rhda_root_hub_desc

`default_nettype wire
